// file: msfl_modem_flow.sv
// modem status mirror, change flags and receive flow levels, Avalon-MM slave
// assumes one clock, byte data in the low lane, rx fifo count from same clock
`include "msfl_params.svh"
module msfl_modem_flow
#(
  parameter int CNT_W = 7
)
(
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic [7:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic             carrier_detect_n,
  input  wire logic             ring_indicator_n,
  input  wire logic             data_set_ready_n,
  input  wire logic             clear_to_send_n,
  input  wire logic [CNT_W-1:0] rx_fifo_count,
  output logic                  request_to_send_n,
  output logic                  data_terminal_ready_n,
  output logic                  loopback_active,
  output logic                  send_resume_char,
  output logic                  send_stop_char,
  output logic                  modem_status_irq
);

  logic [7:0]       line_format_control_q;
  logic [7:0]       modem_output_control_q;
  logic [7:0]       enhanced_feature_control_q;
  logic [7:0]       special_function_control_q;
  logic [7:0]       flow_halt_resume_levels_q;
  logic [7:0]       flow_cfg_q;
  logic [3:0]       delta_q;
  logic [3:0]       delta_set;
  logic [3:0]       line_prev_q;
  logic [3:0]       line_now;
  logic [3:0]       pin_sync;
  logic [7:0]       modem_line_status;
  logic             rd_done_q;
  logic [31:0]      readdata_q;
  logic             rts_n_q;
  logic             resume_pulse_q;
  logic             stop_pulse_q;
  msfl_pkg::msfl_flow_e flow_state_q;
  logic [5:0]       reg_idx;
  logic             aligned;
  logic             loop_en;
  logic             sel_msr;
  logic             sel_tcr;
  logic             wr_en;
  logic             rd_take;
  logic [7:0]       wbyte;
  logic [CNT_W+1:0] fill_ext;
  logic [CNT_W+1:0] resume_lvl;
  logic [CNT_W+1:0] halt_lvl;
  logic             at_resume;
  logic             at_halt;

  msfl_pin_sync
  #(
    .WIDTH   (4),
    .RST_VAL (`MSFL_RST_PINS)
  )
  u_pin_sync
  (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .ce        (ce),
    .pin_async ({carrier_detect_n, ring_indicator_n, data_set_ready_n, clear_to_send_n}),
    .pin_sync  (pin_sync)
  );

  // bus decode
  assign reg_idx = avs_address[7:2];
  assign aligned = (avs_address[1:0] == 2'h0);
  assign wbyte   = avs_writedata[7:0];
  assign loop_en = modem_output_control_q[`MSFL_MCR_LOOP];
  assign sel_msr = aligned && (reg_idx == `MSFL_IDX_STAT_LVL)
                   && !line_format_control_q[`MSFL_LCR_DLAB]
                   && !modem_output_control_q[`MSFL_MCR_OP1_SEL]
                   && !special_function_control_q[`MSFL_SFR_ALT];
  assign sel_tcr = aligned && (reg_idx == `MSFL_IDX_STAT_LVL)
                   && enhanced_feature_control_q[`MSFL_EFR_ENH]
                   && modem_output_control_q[`MSFL_MCR_OP1_SEL]
                   && !special_function_control_q[`MSFL_SFR_ALT];
  assign wr_en   = ce && avs_write && avs_byteenable[0];
  assign rd_take = ce && avs_read && rd_done_q;

  // reads answer one cycle late so read data comes from a register
  assign avs_waitrequest = !ce || (avs_read && !rd_done_q);
  assign avs_readdata    = readdata_q;

  // effective line state: pins inverted, or modem outputs in loopback
  always_comb
  begin
    if (loop_en)
    begin
      line_now[`MSFL_PIN_CD]  = modem_output_control_q[`MSFL_MCR_OP2];
      line_now[`MSFL_PIN_RI]  = modem_output_control_q[`MSFL_MCR_OP1_SEL];
      line_now[`MSFL_PIN_DSR] = modem_output_control_q[`MSFL_MCR_DTR];
      line_now[`MSFL_PIN_CTS] = modem_output_control_q[`MSFL_MCR_RTS];
    end
    else
    begin
      line_now = ~pin_sync;
    end
  end

  assign modem_line_status = {line_now[`MSFL_PIN_CD], line_now[`MSFL_PIN_RI],
                              line_now[`MSFL_PIN_DSR], line_now[`MSFL_PIN_CTS],
                              delta_q};

  // change detection
  assign delta_set[3] = line_now[`MSFL_PIN_CD] ^ line_prev_q[`MSFL_PIN_CD];
  assign delta_set[2] = line_prev_q[`MSFL_PIN_RI] && !line_now[`MSFL_PIN_RI];
  assign delta_set[1] = line_now[`MSFL_PIN_DSR] ^ line_prev_q[`MSFL_PIN_DSR];
  assign delta_set[0] = line_now[`MSFL_PIN_CTS] ^ line_prev_q[`MSFL_PIN_CTS];

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      line_prev_q <= 4'h0;
    end
    else if (ce)
    begin
      line_prev_q <= line_now;
    end
  end

  // change flags: a new change wins over the read clear
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      delta_q <= 4'(`MSFL_RST_MSR);
    end
    else if (ce)
    begin
      if (rd_take && sel_msr)
      begin
        delta_q <= delta_set;
      end
      else
      begin
        delta_q <= delta_q | delta_set;
      end
    end
  end

  assign modem_status_irq = flow_cfg_q[`MSFL_CFG_MS_IRQ_EN] && (|delta_q);

  // control registers
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      line_format_control_q      <= `MSFL_RST_LCR;
      modem_output_control_q     <= `MSFL_RST_MCR;
      enhanced_feature_control_q <= `MSFL_RST_EFR;
      special_function_control_q <= `MSFL_RST_SFR;
      flow_halt_resume_levels_q  <= `MSFL_RST_TCR;
      flow_cfg_q                 <= `MSFL_RST_FLOW_CFG;
    end
    else if (wr_en && aligned)
    begin
      unique case (reg_idx)
        `MSFL_IDX_LCR:
        begin
          line_format_control_q <= wbyte;
        end
        `MSFL_IDX_MCR:
        begin
          if (!line_format_control_q[`MSFL_LCR_DLAB])
          begin
            // upper and op bits need enhanced mode to change
            if (enhanced_feature_control_q[`MSFL_EFR_ENH])
            begin
              modem_output_control_q <= wbyte;
            end
            else
            begin
              modem_output_control_q <= (modem_output_control_q & `MSFL_MCR_EFR_MASK)
                                        | (wbyte & ~`MSFL_MCR_EFR_MASK);
            end
          end
        end
        `MSFL_IDX_STAT_LVL:
        begin
          if (sel_tcr)
          begin
            flow_halt_resume_levels_q <= wbyte;
          end
        end
        `MSFL_IDX_EFR:
        begin
          enhanced_feature_control_q <= wbyte;
        end
        `MSFL_IDX_SFR:
        begin
          special_function_control_q <= wbyte;
        end
        `MSFL_IDX_FLOW_CFG:
        begin
          flow_cfg_q <= wbyte;
        end
        default:
        begin
        end
      endcase
    end
  end

  // read path
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_done_q  <= 1'b0;
      readdata_q <= 32'h0000_0000;
    end
    else if (ce)
    begin
      rd_done_q  <= avs_read && !rd_done_q;
      readdata_q <= 32'h0000_0000;
      if (avs_read && !rd_done_q && aligned)
      begin
        unique case (reg_idx)
          `MSFL_IDX_LCR:
          begin
            readdata_q[7:0] <= line_format_control_q;
          end
          `MSFL_IDX_MCR:
          begin
            if (!line_format_control_q[`MSFL_LCR_DLAB])
            begin
              readdata_q[7:0] <= modem_output_control_q;
            end
          end
          `MSFL_IDX_STAT_LVL:
          begin
            if (sel_msr)
            begin
              readdata_q[7:0] <= modem_line_status;
            end
            else if (sel_tcr)
            begin
              readdata_q[7:0] <= flow_halt_resume_levels_q;
            end
          end
          `MSFL_IDX_EFR:
          begin
            readdata_q[7:0] <= enhanced_feature_control_q;
          end
          `MSFL_IDX_SFR:
          begin
            readdata_q[7:0] <= special_function_control_q;
          end
          `MSFL_IDX_FLOW_CFG:
          begin
            readdata_q[7:0] <= flow_cfg_q;
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // fill levels, four entries per step
  assign fill_ext   = {2'b00, rx_fifo_count};
  assign resume_lvl = (CNT_W+2)'(flow_halt_resume_levels_q[`MSFL_TCR_RESUME_HI:`MSFL_TCR_RESUME_LO])
                      << `MSFL_LEVEL_SHIFT;
  assign halt_lvl   = (CNT_W+2)'(flow_halt_resume_levels_q[`MSFL_TCR_HALT_HI:`MSFL_TCR_HALT_LO])
                      << `MSFL_LEVEL_SHIFT;
  assign at_resume  = fill_ext <= resume_lvl;
  assign at_halt    = fill_ext >= halt_lvl;

  // request to send pin; halt wins when both levels hit
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rts_n_q <= 1'b1;
    end
    else if (ce)
    begin
      if (!flow_cfg_q[`MSFL_CFG_AUTO_RTS] || loop_en)
      begin
        rts_n_q <= !modem_output_control_q[`MSFL_MCR_RTS];
      end
      else if (at_halt)
      begin
        rts_n_q <= 1'b1;
      end
      else if (at_resume)
      begin
        rts_n_q <= 1'b0;
      end
    end
  end

  assign request_to_send_n     = rts_n_q;
  assign data_terminal_ready_n = loop_en || !modem_output_control_q[`MSFL_MCR_DTR];
  assign loopback_active       = loop_en;

  // software flow: one stop char on halt, one resume char on recovery
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      flow_state_q   <= msfl_pkg::MSFL_FLOW_RUN;
      resume_pulse_q <= 1'b0;
      stop_pulse_q   <= 1'b0;
    end
    else if (ce)
    begin
      resume_pulse_q <= 1'b0;
      stop_pulse_q   <= 1'b0;
      if (!flow_cfg_q[`MSFL_CFG_AUTO_SW])
      begin
        flow_state_q <= msfl_pkg::MSFL_FLOW_RUN;
      end
      else
      begin
        unique case (flow_state_q)
          msfl_pkg::MSFL_FLOW_RUN:
          begin
            if (at_halt)
            begin
              stop_pulse_q <= 1'b1;
              flow_state_q <= msfl_pkg::MSFL_FLOW_HALTED;
            end
          end
          msfl_pkg::MSFL_FLOW_HALTED:
          begin
            if (at_resume && !at_halt)
            begin
              resume_pulse_q <= 1'b1;
              flow_state_q   <= msfl_pkg::MSFL_FLOW_RUN;
            end
          end
          default:
          begin
            flow_state_q <= msfl_pkg::MSFL_FLOW_RUN;
          end
        endcase
      end
    end
  end

  assign send_resume_char = resume_pulse_q;
  assign send_stop_char   = stop_pulse_q;

endmodule

// file: msfl_params.svh
// constants for the modem status and receive flow level block
// assumes inclusion by bare name from each design file that needs it
`ifndef MSFL_PARAMS_SVH
`define MSFL_PARAMS_SVH

// register indices; byte address is four times the index
`define MSFL_IDX_LCR        6'h03
`define MSFL_IDX_MCR        6'h04
`define MSFL_IDX_STAT_LVL   6'h06
`define MSFL_IDX_EFR        6'h0E
`define MSFL_IDX_SFR        6'h0F
`define MSFL_IDX_FLOW_CFG   6'h10

// reset values
`define MSFL_RST_LCR        8'h00
`define MSFL_RST_MCR        8'h00
`define MSFL_RST_MSR        8'h00
`define MSFL_RST_TCR        8'h00
`define MSFL_RST_EFR        8'h00
`define MSFL_RST_SFR        8'h00
`define MSFL_RST_FLOW_CFG   8'h00
`define MSFL_RST_PINS       4'hF

// line format control fields
`define MSFL_LCR_DLAB       7

// modem output control fields
`define MSFL_MCR_DTR        0
`define MSFL_MCR_RTS        1
`define MSFL_MCR_OP1_SEL    2
`define MSFL_MCR_OP2        3
`define MSFL_MCR_LOOP       4
`define MSFL_MCR_EFR_MASK   8'hEC

// enhanced feature and special function fields
`define MSFL_EFR_ENH        4
`define MSFL_SFR_ALT        2

// status layout
`define MSFL_MSR_CD         7
`define MSFL_MSR_RI         6
`define MSFL_MSR_DSR        5
`define MSFL_MSR_CTS        4
`define MSFL_MSR_DCD        3
`define MSFL_MSR_TERI       2
`define MSFL_MSR_DDSR       1
`define MSFL_MSR_DCTS       0

// pin vector layout: cd, ri, dsr, cts
`define MSFL_PIN_CTS        0
`define MSFL_PIN_DSR        1
`define MSFL_PIN_RI         2
`define MSFL_PIN_CD         3

// flow config fields
`define MSFL_CFG_AUTO_RTS   0
`define MSFL_CFG_AUTO_SW    1
`define MSFL_CFG_MS_IRQ_EN  2

// level fields, scaled by four
`define MSFL_TCR_RESUME_HI  7
`define MSFL_TCR_RESUME_LO  4
`define MSFL_TCR_HALT_HI    3
`define MSFL_TCR_HALT_LO    0
`define MSFL_LEVEL_SHIFT    2

`endif

// file: msfl_pkg.sv
// types shared by the modem status and flow level block
// assumes nothing beyond a SystemVerilog compiler
package msfl_pkg;

  // software flow state, one-hot
  typedef enum logic [1:0]
  {
    MSFL_FLOW_RUN    = 2'b01,
    MSFL_FLOW_HALTED = 2'b10
  } msfl_flow_e;

endpackage

// file: msfl_pin_sync.sv
// three-stage input synchroniser with agreement filter, one lane per bit
// assumes asynchronous pin inputs and one system clock
module msfl_pin_sync
#(
  parameter int          WIDTH   = 4,
  parameter logic [3:0]  RST_VAL = 4'hF
)
(
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_sync
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_lane
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic out_q;

      always_ff @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
        begin
          s1_q  <= RST_VAL[gi];
          s2_q  <= RST_VAL[gi];
          s3_q  <= RST_VAL[gi];
          out_q <= RST_VAL[gi];
        end
        else if (ce)
        begin
          s1_q <= pin_async[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // change accepted once stages two and three agree
          if (s2_q == s3_q)
          begin
            out_q <= s3_q;
          end
        end
      end

      assign pin_sync[gi] = out_q;
    end
  endgenerate

endmodule

// file: msfl_modem_flow_chk.sv
// checker for the modem status and receive flow level block
// assumes ce held high in use; bound to the top module below
module msfl_modem_flow_chk
#(
  parameter int CNT_W = 7
)
(
  input wire logic             clk_sys,
  input wire logic             resetn,
  input wire logic             ce,
  input wire logic [7:0]       avs_address,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic [31:0]      avs_writedata,
  input wire logic [3:0]       avs_byteenable,
  input wire logic [31:0]      avs_readdata,
  input wire logic             avs_waitrequest,
  input wire logic             carrier_detect_n,
  input wire logic             ring_indicator_n,
  input wire logic             data_set_ready_n,
  input wire logic             clear_to_send_n,
  input wire logic [CNT_W-1:0] rx_fifo_count,
  input wire logic             request_to_send_n,
  input wire logic             send_resume_char,
  input wire logic             send_stop_char,
  input wire logic             modem_status_irq
);
  logic [7:0] lcr_q, mcr_q, efr_q, sfr_q, cfg_q, tcr_q, wd;
  logic [3:0] st, st_q, chg_q, quiet_q;
  logic [5:0] idx;
  logic       sure_q, swh_q, wr, rd_ok, msr_rd, halt, res, loop;
  assign idx = avs_address[7:2];
  assign wd = avs_writedata[7:0];
  assign wr = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[1:0] == 2'h0;
  assign rd_ok = avs_read && !avs_waitrequest;
  assign loop = mcr_q[4];
  assign msr_rd = rd_ok && avs_address == 8'h18 && !lcr_q[7] && !mcr_q[2] && !sfr_q[2];
  assign st = loop ? {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]}
    : ~{carrier_detect_n, ring_indicator_n, data_set_ready_n, clear_to_send_n};
  assign halt = int'(rx_fifo_count) >= 4 * tcr_q[3:0];
  assign res = int'(rx_fifo_count) <= 4 * tcr_q[7:4];
  // shadow of the software-visible control registers
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      {lcr_q, mcr_q, efr_q, sfr_q, cfg_q, tcr_q} <= 48'h0;
    end
    else if (wr)
    begin
      if (idx == 6'h03) lcr_q <= wd;
      if (idx == 6'h04 && !lcr_q[7]) mcr_q <= efr_q[4] ? wd : (mcr_q & 8'hEC) | (wd & 8'h13);
      if (idx == 6'h0E) efr_q <= wd;
      if (idx == 6'h0F) sfr_q <= wd;
      if (idx == 6'h10) cfg_q <= wd;
      if (idx == 6'h06 && efr_q[4] && mcr_q[2] && !sfr_q[2]) tcr_q <= wd;
    end
  // expected change flags, unaffected by sync delay once quiet
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      st_q <= 4'h0;
      chg_q <= 4'h0;
      sure_q <= 1'h1;
    end
    else
    begin
      st_q <= st;
      chg_q <= (msr_rd ? 4'h0 : chg_q)
        | {st[3] ^ st_q[3], st_q[2] & !st[2], st[1] ^ st_q[1], st[0] ^ st_q[0]};
      if (msr_rd) sure_q <= quiet_q >= 4'h8;
    end
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn) quiet_q <= 4'h0;
    else if (wr || st != st_q || !ce) quiet_q <= 4'h0;
    else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn) swh_q <= 1'h0;
    else if (!cfg_q[1]) swh_q <= 1'h0;
    else if (halt) swh_q <= 1'h1;
    else if (res) swh_q <= 1'h0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn || !ce);
  sequence s_rd_wait;
    avs_read && avs_waitrequest;
  endsequence
  sequence s_msr_quiet;
    msr_rd && quiet_q >= 4'h8;
  endsequence
  sequence s_auto;
    cfg_q[0] && !loop;
  endsequence
  AST_RD_WAIT: assert property (s_rd_wait |=> !avs_waitrequest)
    else $error("read not answered one cycle later");
  AST_MIRROR: assert property (s_msr_quiet |-> avs_readdata[7:4] == st)
    else $error("status mirror bits wrong");
  AST_DELTA: assert property (s_msr_quiet and sure_q
    |-> avs_readdata[3:0] == chg_q)
    else $error("change flags wrong");
  AST_IRQ: assert property (quiet_q >= 4'h8 && sure_q
    |-> modem_status_irq == (cfg_q[2] && chg_q != 4'h0))
    else $error("modem status interrupt wrong");
  AST_RTS_HALT: assert property (s_auto and halt |=> request_to_send_n)
    else $error("rts not released at halt level");
  AST_RTS_RESUME: assert property (s_auto and res && !halt |=> !request_to_send_n)
    else $error("rts not asserted at resume level");
  AST_RTS_HOLD: assert property (s_auto and !res && !halt |=> $stable(request_to_send_n))
    else $error("rts moved between levels");
  AST_RTS_MANUAL: assert property (!cfg_q[0] || loop |=> request_to_send_n == !$past(mcr_q[1]))
    else $error("manual rts wrong");
  AST_SW_STOP: assert property (cfg_q[1] && !swh_q && halt |=> send_stop_char)
    else $error("stop character not sent");
  AST_SW_RESUME: assert property (cfg_q[1] && swh_q && res && !halt |=> send_resume_char)
    else $error("resume character not sent");
  AST_TCR_RD: assert property (rd_ok && avs_address == 8'h18 && efr_q[4] && mcr_q[2] && !sfr_q[2]
    |-> avs_readdata[7:0] == tcr_q)
    else $error("level register readback wrong");
endmodule

bind msfl_modem_flow msfl_modem_flow_chk #(.CNT_W(CNT_W)) u_chk (.*);

// file: msfl_modem_peer.sv
// modem peer model driving the four active-low status lines
// assumes the bench asks for new line levels just after a rising edge
module msfl_modem_peer
(
  input  wire logic       clk_sys,
  input  wire logic [3:0] want,
  output logic            carrier_detect_n,
  output logic            ring_indicator_n,
  output logic            data_set_ready_n,
  output logic            clear_to_send_n
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_sys)
    {carrier_detect_n, ring_indicator_n, data_set_ready_n, clear_to_send_n} <= want;
endmodule

// file: msfl_modem_flow_tb.sv
// self-checking bench for the modem status and receive flow level block
// assumes the peer model on the modem lines and the bench as bus master
module msfl_modem_flow_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, resetn, avs_read, avs_write, avs_waitrequest, request_to_send_n;
  logic        modem_status_irq, send_resume_char, send_stop_char, loopback_active;
  logic        carrier_detect_n, ring_indicator_n, data_set_ready_n, clear_to_send_n;
  logic        data_terminal_ready_n;
  logic [7:0]  avs_address, rd_q;
  logic [31:0] avs_writedata, avs_readdata;
  logic [6:0]  rx_fifo_count;
  logic [3:0]  want;
  int          miscompares, num_checks, n_stop, n_res, r0;
  int          cnt_tab [6] = '{8, 19, 20, 21, 9, 8};
  logic        rts_tab [6] = '{0, 0, 1, 1, 1, 0};
  `define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
  msfl_modem_flow dut (.ce(1'h1), .avs_byteenable(4'hF), .*);
  msfl_modem_peer peer (.*);
  initial
  begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys)
  begin
    if (send_stop_char === 1'h1) n_stop++;
    if (send_resume_char === 1'h1) n_res++;
  end
  task automatic end_sim;
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [5:0] i, input logic [7:0] d);
    avs_address <= {i, 2'h0};
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    // only the watchdog ends a wait that never answers
    do
    begin
      @(negedge clk_sys);
    end
    while (avs_waitrequest !== 1'h0);
    rd_q = avs_readdata[7:0];
    @(posedge clk_sys);
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    acc(1'h1, i, d);
  endtask
  task automatic rdc(input logic [5:0] i, input logic [7:0] e);
    acc(1'h0, i, 8'h00);
    `CHK("readdata", e, rd_q)
  endtask
  task automatic sig(input string nm, input logic e, ref logic g);
    @(negedge clk_sys);
    `CHK(nm, e, g)
    @(posedge clk_sys);
  endtask
  initial
  begin
    #50us;
    miscompares++;
    end_sim;
  end
  initial
  begin
    resetn = 1'h0;
    {avs_read, avs_write, avs_address, avs_writedata, rx_fifo_count} = '0;
    {miscompares, num_checks, n_stop, n_res, r0} = '0;
    want = 4'hF;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'h1;
    @(posedge clk_sys);
    rdc(6'h06, 8'h00);
    want <= 4'h7;
    repeat (10) @(posedge clk_sys);
    wr(6'h03, 8'h80);
    rdc(6'h06, 8'h00);
    wr(6'h03, 8'h00);
    rdc(6'h06, 8'h88);
    rdc(6'h06, 8'h80);
    want <= 4'h3;
    repeat (10) @(posedge clk_sys);
    rdc(6'h06, 8'hC0);
    want <= 4'h7;
    repeat (10) @(posedge clk_sys);
    rdc(6'h06, 8'h84);
    wr(6'h10, 8'h04);
    want <= 4'h4;
    repeat (10) @(posedge clk_sys);
    sig("irq", 1'h1, modem_status_irq);
    rdc(6'h06, 8'hB3);
    sig("irq", 1'h0, modem_status_irq);
    wr(6'h0E, 8'h10);
    wr(6'h04, 8'h19);
    repeat (4) @(posedge clk_sys);
    sig("loopback", 1'h1, loopback_active);
    sig("dtr", 1'h1, data_terminal_ready_n);
    rdc(6'h06, 8'hA1);
    wr(6'h04, 8'h05);
    sig("dtr", 1'h0, data_terminal_ready_n);
    wr(6'h06, 8'h25);
    rdc(6'h06, 8'h25);
    wr(6'h0F, 8'h04);
    rdc(6'h06, 8'h00);
    wr(6'h0F, 8'h00);
    wr(6'h10, 8'h03);
    foreach (cnt_tab[i])
    begin
      if (i == 5) r0 = n_res;
      rx_fifo_count <= 7'(cnt_tab[i]);
      repeat (2) @(posedge clk_sys);
      sig("rts", rts_tab[i], request_to_send_n);
    end
    `CHK("stop", 1, n_stop)
    `CHK("resume", 1, n_res - r0)
    rdc(6'h3F, 8'h00);
    end_sim;
  end
endmodule
